// ---- shared/tccio_pkg.sv ----
// shared constants, types and helpers of the capture/compare i/o select block
package tccio_pkg;
  // ------------------------------------------------------------
  // widths and counts
  // ------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  localparam int IOCTL_W = 8;
  localparam int FIELD_W = 4;
  localparam int NUM_CH = 2;
  localparam int NUM_UNIT = 4;
  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADR_IOCTL1 = 6'h00;
  localparam logic [ADDR_W-1:0] ADR_IOCTL2 = 6'h04;
  localparam logic [ADDR_W-1:0] ADR_RUN = 6'h08;
  localparam logic [ADDR_W-1:0] ADR_STATUS = 6'h0C;
  localparam logic [ADDR_W-1:0] ADR_MASK = 6'h10;
  localparam logic [ADDR_W-1:0] ADR_CNT1 = 6'h14;
  localparam logic [ADDR_W-1:0] ADR_GRA1 = 6'h18;
  localparam logic [ADDR_W-1:0] ADR_GRB1 = 6'h1C;
  localparam logic [ADDR_W-1:0] ADR_CNT2 = 6'h20;
  localparam logic [ADDR_W-1:0] ADR_GRA2 = 6'h24;
  localparam logic [ADDR_W-1:0] ADR_GRB2 = 6'h28;
  // ------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------
  localparam logic [IOCTL_W-1:0] IOCTL_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] GR_RST = 16'hFFFF;
  localparam logic [NUM_CH-1:0] RUN_RST = 2'h0;
  localparam logic [NUM_UNIT-1:0] FLAG_RST = 4'h0;
  localparam logic [DATA_W-1:0] RD_IDLE = 16'h0000;
  localparam int FLD_A_LSB = 0;
  localparam int FLD_B_LSB = 4;
  // compare action; in capture mode 00 rising, 01 falling, 1x both edges
  typedef enum logic [1:0] {
    ACT_OFF = 2'b00,
    ACT_LOW = 2'b01,
    ACT_HIGH = 2'b10,
    ACT_TOGGLE = 2'b11
  } tccio_action_e;
  // one 4-bit function field: bit3 capture, bit2 initial level, bits1:0 action
  typedef struct packed {
    logic capture;
    logic init_high;
    tccio_action_e action;
  } tccio_field_s;
  // drive side of a two-way timer pin
  typedef struct packed {
    logic drive;
    logic enable;
  } tccio_pin_s;
  // pick the field of register a (lower) or b (upper)
  function automatic tccio_field_s field_of(input logic [IOCTL_W-1:0] ioctl,
                                            input logic upper);
    field_of = upper ? tccio_field_s'(ioctl[FLD_B_LSB +: FIELD_W])
                     : tccio_field_s'(ioctl[FLD_A_LSB +: FIELD_W]);
  endfunction
  // zero-extend a narrow register to the read bus
  function automatic logic [DATA_W-1:0] widen(input logic [IOCTL_W-1:0] v);
    widen = {{(DATA_W-IOCTL_W){1'b0}}, v};
  endfunction
endpackage

// ---- test/tccio_pin_model.sv ----
// far-side model of one timer pin: resolves the shared line level
`timescale 1ns/1ps
module tccio_pin_model
  import tccio_pkg::*;
(
  input wire tccio_pin_s pin_o_i,
  input wire logic ext_level_i,
  output logic level_o
);
  // --------------------------------------------------------------
  // line resolution
  // --------------------------------------------------------------
  // the far side lets go of the line while the timer drives it
  always_comb begin
    if (pin_o_i.enable) begin
      level_o = pin_o_i.drive;
    end else begin
      level_o = ext_level_i;
    end
  end
endmodule

// ---- test/test_tccio_top.sv ----
// self-checking bench of the timer capture/compare i/o select block
`timescale 1ns/1ps
module test_tccio_top;
  import tccio_pkg::*;
  // --------------------------------------------------------------
  // stimulus tables
  // --------------------------------------------------------------
  localparam logic [ADDR_W-1:0] RST_ADR [4] = '{ADR_IOCTL1, ADR_IOCTL2, ADR_GRA1, 6'h3C};
  localparam logic [DATA_W-1:0] RST_VAL [4] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000};
  localparam logic [ADDR_W-1:0] CAP_ADR [6] = '{ADR_IOCTL1, ADR_IOCTL1, ADR_IOCTL1,
                                               ADR_IOCTL1, ADR_IOCTL2, ADR_IOCTL2};
  localparam logic [ADDR_W-1:0] CAP_CNT [6] = '{ADR_CNT1, ADR_CNT1, ADR_CNT1,
                                               ADR_CNT1, ADR_CNT2, ADR_CNT2};
  localparam logic [ADDR_W-1:0] CAP_GR [6] = '{ADR_GRA1, ADR_GRA1, ADR_GRA1,
                                              ADR_GRA1, ADR_GRA2, ADR_GRB2};
  localparam logic [7:0] CAP_CODE [6] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'hD0};
  localparam int CAP_PIN [6] = '{0, 0, 0, 0, 2, 3};
  localparam logic [5:0] CAP_RISE = 6'b011101;
  localparam logic [5:0] CAP_FALL = 6'b101110;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_r = '0;
  logic [DATA_W-1:0] wdata_r = '0;
  logic wr_r = 1'b0;
  logic rd_r = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic irq;
  logic [3:0] ext_lvl = 4'h0;
  wire [3:0] lvl;
  tccio_pin_s pin_o [4];
  int num_errors = 0;
  int cmp_count = 0;
  // clock at 125 MHz
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  tccio_top u_tccio_top (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_r), .wr_data_i(wdata_r),
    .wr_i(wr_r), .rd_i(rd_r), .rd_data_o(rd_data), .irq_o(irq),
    .ch1_pin_a_i(lvl[0]), .ch1_pin_b_i(lvl[1]), .ch2_pin_a_i(lvl[2]), .ch2_pin_b_i(lvl[3]),
    .ch1_pin_a_o(pin_o[0]), .ch1_pin_b_o(pin_o[1]), .ch2_pin_a_o(pin_o[2]),
    .ch2_pin_b_o(pin_o[3])
  );
  // one far-side model on every pin
  for (genvar g = 0; g < 4; g++) begin : g_pin
    tccio_pin_model u_pin (.pin_o_i(pin_o[g]), .ext_level_i(ext_lvl[g]), .level_o(lvl[g]));
  end
  // --------------------------------------------------------------
  // bus cycles, comparisons and verdict
  // --------------------------------------------------------------
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr_r <= a;
    wdata_r <= d;
    wr_r <= 1'b1;
    @(posedge mclk_i);
    wr_r <= 1'b0;
    @(posedge mclk_i);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    addr_r <= a;
    rd_r <= 1'b1;
    @(posedge mclk_i);
    rd_r <= 1'b0;
    #1 d = rd_data;
    @(posedge mclk_i);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // pin level after a compare match: low, high or inverted initial level
  function automatic logic exp_drive(input logic [3:0] c);
    return (c[1:0] == 2'b11) ? ~c[2] : c[1];
  endfunction
  // watchdog well beyond the roughly 1100 to 1300 cycles the run needs
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    finish_test();
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    logic [15:0] d;
    logic [15:0] c;
    logic [3:0] code;
    logic ex;
    int s;
    int p;
    s = $urandom(81967);
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    // reset values, one unmapped address among them
    for (int i = 0; i < 4; i++) begin
      bus_rd(RST_ADR[i], d);
      cmp16("reset value", RST_VAL[i], d);
    end
    // kept above every counter value that the run reaches
    d = 16'h8000 | 16'($urandom());
    bus_wr(ADR_GRB1, d);
    bus_rd(ADR_GRB1, c);
    cmp16("grb1 readback", d, c);
    // a field in the low nibble: compare high on a, capture on b
    bus_wr(ADR_IOCTL1, 16'h0082);
    settle(2);
    cmp1("field layout", 1'b1, pin_o[0].enable);
    cmp1("b pin enable", 1'b0, pin_o[1].enable);
    // every compare code of register a, initial level then match level
    bus_wr(ADR_MASK, 16'h0001);
    for (int k = 0; k < 8; k++) begin
      code = 4'(k);
      bus_wr(ADR_RUN, 16'h0000);
      bus_wr(ADR_CNT1, 16'h0000);
      bus_wr(ADR_IOCTL1, {12'h000, code});
      bus_wr(ADR_GRA1, 16'h0010 + 16'($urandom_range(31)));
      bus_wr(ADR_STATUS, 16'h000F);
      settle(20);
      cmp1("compare enable", code[1:0] != 2'b00, pin_o[0].enable);
      if (code[1:0] != 2'b00) cmp1("initial level", code[2], pin_o[0].drive);
      bus_wr(ADR_RUN, 16'h0001);
      for (int w = 0; w < 100 && irq !== 1'b1; w++) @(posedge mclk_i);
      cmp1("match interrupt", 1'b1, irq);
      settle(2);
      if (code[1:0] != 2'b00) cmp1("match level", exp_drive(code), pin_o[0].drive);
      settle(20);
      if (code[1:0] != 2'b00) cmp1("held level", exp_drive(code), pin_o[0].drive);
    end
    // interrupt masked, unmasked and cleared
    bus_rd(ADR_STATUS, d);
    cmp16("status after match", 16'h0001, d);
    bus_wr(ADR_MASK, 16'h0000);
    settle(1);
    cmp1("masked interrupt", 1'b0, irq);
    bus_wr(ADR_MASK, 16'h0001);
    settle(1);
    cmp1("unmasked interrupt", 1'b1, irq);
    bus_wr(ADR_STATUS, 16'h0001);
    settle(1);
    cmp1("cleared interrupt", 1'b0, irq);
    // capture edges; the neighbour pin toggles first and must not capture
    bus_wr(ADR_RUN, 16'h0003);
    for (int i = 0; i < 6; i++) begin
      bus_wr(CAP_ADR[i], {8'h00, CAP_CODE[i]});
      bus_wr(CAP_CNT[i], 16'h1000 + 16'($urandom_range(16'h4000)));
      bus_wr(ADR_STATUS, 16'h000F);
      for (int e = 0; e < 4; e++) begin
        p = (e < 2) ? (CAP_PIN[i] ^ 1) : CAP_PIN[i];
        ex = (e < 2) ? 1'b0 : ((e == 2) ? CAP_RISE[i] : CAP_FALL[i]);
        bus_rd(CAP_CNT[i], c);
        ext_lvl[p] <= (e % 2 == 0);
        settle(8);
        bus_rd(ADR_STATUS, d);
        cmp1("capture flag", ex, d[CAP_PIN[i]]);
        if (ex) begin
          bus_rd(CAP_GR[i], d);
          cmp1("captured count", 1'b1, 16'(d - c) inside {[1:12]});
        end
        bus_wr(ADR_STATUS, 16'h000F);
      end
    end
    // channel 2 register a: initial one, low at match, then output off
    bus_wr(ADR_RUN, 16'h0001);
    bus_wr(ADR_CNT2, 16'h0000);
    bus_wr(ADR_GRA2, 16'h0010 + 16'($urandom_range(31)));
    bus_wr(ADR_IOCTL2, 16'h0005);
    settle(2);
    cmp1("ch2 a enable", 1'b1, pin_o[2].enable);
    cmp1("ch2 a initial level", 1'b1, pin_o[2].drive);
    bus_wr(ADR_RUN, 16'h0002);
    settle(60);
    cmp1("ch2 a match level", 1'b0, pin_o[2].drive);
    cmp1("ch2 b enable", 1'b0, pin_o[3].enable);
    bus_wr(ADR_IOCTL2, 16'h0004);
    settle(2);
    cmp1("ch2 a disabled", 1'b0, pin_o[2].enable);
    finish_test();
  end
endmodule

// ---- verilog/tccio_gr_unit.sv ----
// one general register with its pin: compare output or edge capture
`timescale 1ns/1ps
module tccio_gr_unit
  import tccio_pkg::*;
#(
  parameter bit OUT_ALLOWED = 1'b1
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire tccio_field_s field_i,
  input wire logic run_i,
  input wire logic [CNT_W-1:0] count_i,
  input wire logic pin_raw_i,
  input wire logic gr_we_i,
  input wire logic [CNT_W-1:0] gr_wdata_i,
  output logic [CNT_W-1:0] gr_o,
  output tccio_pin_s pin_o,
  output logic event_o
);
  logic sync1_reg, sync2_reg, sync3_reg, level_reg;
  logic agree, rise, fall, cap_hit, match;

  // ------------------------------------------------------------
  // pin synchroniser and edge detection
  // ------------------------------------------------------------
  // three stages; a new level counts once stage two and three agree on it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_raw_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // accepted pin level; a one-cycle glitch never reaches it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= 1'b0;
    end else if (agree) begin
      level_reg <= sync3_reg;
    end
  end

  assign agree = (sync2_reg == sync3_reg);
  assign rise = agree & sync3_reg & ~level_reg;
  assign fall = agree & ~sync3_reg & level_reg;
  // bit2 plays no part in capture, source is always this unit's own pin
  assign cap_hit = field_i.capture & (field_i.action[1] ? (rise | fall) :
                   field_i.action[0] ? fall : rise);
  assign match = ~field_i.capture & run_i & (count_i == gr_o);
  assign event_o = cap_hit | match;

  // ------------------------------------------------------------
  // general register: capture wins over a software write
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gr_o <= GR_RST;
    end else if (cap_hit) begin
      gr_o <= count_i;
    end else if (gr_we_i) begin
      gr_o <= gr_wdata_i;
    end
  end

  // ------------------------------------------------------------
  // compare output pin
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= '0;
    end else begin
      pin_o.enable <= OUT_ALLOWED & ~field_i.capture & (field_i.action != ACT_OFF);
      if (!run_i) begin
        pin_o.drive <= field_i.init_high;
      end else if (match) begin
        unique case (field_i.action)
          ACT_LOW: pin_o.drive <= 1'b0;
          ACT_HIGH: pin_o.drive <= 1'b1;
          ACT_TOGGLE: pin_o.drive <= ~pin_o.drive;
          ACT_OFF: pin_o.drive <= pin_o.drive;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence pin_rise_s;
    !pin_raw_i [*2] ##1 pin_raw_i [*2];
  endsequence
  logic rise_mode;
  assign rise_mode = field_i.capture & (field_i.action == ACT_OFF);
  rise_capture_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (pin_rise_s ##0 rise_mode [*3]) |-> event_o)
    else $error("rising edge not captured");
  capture_copy_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cap_hit |=> gr_o == $past(count_i))
    else $error("capture did not load counter");
  one_capture_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (cap_hit && !field_i.action[1]) |=> !cap_hit)
    else $error("single edge captured twice");
  init_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !run_i |=> pin_o.drive == $past(field_i.init_high))
    else $error("initial level not applied while stopped");
  toggle_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (match && field_i.action == ACT_TOGGLE) |=> pin_o.drive != $past(pin_o.drive))
    else $error("toggle on match missing");
  hold_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (run_i && !match) |=> $stable(pin_o.drive))
    else $error("pin level moved without match");
endmodule

// ---- verilog/tccio_top.sv ----
// timer capture/compare i/o select: two channels, registers a and b each
`timescale 1ns/1ps
module tccio_top
  import tccio_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic irq_o,
  input wire logic ch1_pin_a_i,
  input wire logic ch1_pin_b_i,
  input wire logic ch2_pin_a_i,
  input wire logic ch2_pin_b_i,
  output tccio_pin_s ch1_pin_a_o,
  output tccio_pin_s ch1_pin_b_o,
  output tccio_pin_s ch2_pin_a_o,
  output tccio_pin_s ch2_pin_b_o
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [IOCTL_W-1:0] ioctl_reg [NUM_CH];
  logic [NUM_CH-1:0] run_reg;
  logic [CNT_W-1:0] cnt_reg [NUM_CH];
  logic [NUM_UNIT-1:0] flag_reg;
  logic [NUM_UNIT-1:0] mask_reg;
  logic [NUM_UNIT-1:0] flag_next;
  logic [NUM_UNIT-1:0] mask_next;
  logic [DATA_W-1:0] rd_next;

  // unit index: 0 ch1 a, 1 ch1 b, 2 ch2 a, 3 ch2 b
  logic [NUM_UNIT-1:0] pin_raw;
  logic [NUM_UNIT-1:0] gr_we;
  logic [NUM_UNIT-1:0] event_w;
  logic [CNT_W-1:0] gr_w [NUM_UNIT];
  tccio_pin_s pin_w [NUM_UNIT];
  logic [ADDR_W-1:0] gr_addr [NUM_UNIT];
  logic [ADDR_W-1:0] ioctl_addr [NUM_CH];
  logic [ADDR_W-1:0] cnt_addr [NUM_CH];

  // ------------------------------------------------------------
  // address tables per channel and unit
  // ------------------------------------------------------------
  assign ioctl_addr[0] = ADR_IOCTL1;
  assign ioctl_addr[1] = ADR_IOCTL2;
  assign cnt_addr[0] = ADR_CNT1;
  assign cnt_addr[1] = ADR_CNT2;
  assign gr_addr[0] = ADR_GRA1;
  assign gr_addr[1] = ADR_GRB1;
  assign gr_addr[2] = ADR_GRA2;
  assign gr_addr[3] = ADR_GRB2;

  // raw pin levels into the units
  assign pin_raw[0] = ch1_pin_a_i;
  assign pin_raw[1] = ch1_pin_b_i;
  assign pin_raw[2] = ch2_pin_a_i;
  assign pin_raw[3] = ch2_pin_b_i;

  // ------------------------------------------------------------
  // i/o control registers
  // ------------------------------------------------------------
  // both fields are plain read/write bits, cleared by reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ioctl_reg[0] <= IOCTL_RST;
      ioctl_reg[1] <= IOCTL_RST;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_i && addr_i == ioctl_addr[c]) begin
          ioctl_reg[c] <= wr_data_i[IOCTL_W-1:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // counter run bits
  // ------------------------------------------------------------
  // bit 0 runs channel 1, bit 1 runs channel 2
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_reg <= RUN_RST;
    end else if (wr_i && addr_i == ADR_RUN) begin
      run_reg <= wr_data_i[NUM_CH-1:0];
    end
  end

  // ------------------------------------------------------------
  // channel counters
  // ------------------------------------------------------------
  // a software write wins over the count step
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg[0] <= CNT_RST;
      cnt_reg[1] <= CNT_RST;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_i && addr_i == cnt_addr[c]) begin
          cnt_reg[c] <= wr_data_i[CNT_W-1:0];
        end else if (run_reg[c]) begin
          cnt_reg[c] <= CNT_W'(cnt_reg[c] + CNT_ONE);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // general register units
  // ------------------------------------------------------------
  // b units never drive their pin: compare codes there only set the flag, capture codes still capture
  for (genvar u = 0; u < NUM_UNIT; u++) begin : g_unit
    assign gr_we[u] = wr_i && (addr_i == gr_addr[u]);
    tccio_gr_unit #(
      .OUT_ALLOWED((u % 2) == 0)
    ) u_gr (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .field_i(field_of(ioctl_reg[u / 2], (u % 2) == 1)),
      .run_i(run_reg[u / 2]),
      .count_i(cnt_reg[u / 2]),
      .pin_raw_i(pin_raw[u]),
      .gr_we_i(gr_we[u]),
      .gr_wdata_i(wr_data_i[CNT_W-1:0]),
      .gr_o(gr_w[u]),
      .pin_o(pin_w[u]),
      .event_o(event_w[u])
    );
  end

  // pin drives come straight from the unit flip-flops
  assign ch1_pin_a_o = pin_w[0];
  assign ch1_pin_b_o = pin_w[1];
  assign ch2_pin_a_o = pin_w[2];
  assign ch2_pin_b_o = pin_w[3];

  // ------------------------------------------------------------
  // event flags and interrupt
  // ------------------------------------------------------------
  // write one to clear; a new event in the same cycle keeps its bit set
  always_comb begin
    flag_next = flag_reg;
    mask_next = mask_reg;
    if (wr_i && addr_i == ADR_STATUS) begin
      flag_next = flag_reg & ~wr_data_i[NUM_UNIT-1:0];
    end
    if (wr_i && addr_i == ADR_MASK) begin
      mask_next = wr_data_i[NUM_UNIT-1:0];
    end
    flag_next = flag_next | event_w;
  end

  // flags, mask and the level interrupt
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= FLAG_RST;
      mask_reg <= FLAG_RST;
      irq_o <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      mask_reg <= mask_next;
      irq_o <= |(flag_next & mask_next);
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // unmapped addresses read as zero
  always_comb begin
    rd_next = RD_IDLE;
    unique case (addr_i)
      ADR_IOCTL1: rd_next = widen(ioctl_reg[0]);
      ADR_IOCTL2: rd_next = widen(ioctl_reg[1]);
      ADR_RUN: rd_next = widen({{(IOCTL_W-NUM_CH){1'b0}}, run_reg});
      ADR_STATUS: rd_next = widen({{(IOCTL_W-NUM_UNIT){1'b0}}, flag_reg});
      ADR_MASK: rd_next = widen({{(IOCTL_W-NUM_UNIT){1'b0}}, mask_reg});
      ADR_CNT1: rd_next = cnt_reg[0];
      ADR_GRA1: rd_next = gr_w[0];
      ADR_GRB1: rd_next = gr_w[1];
      ADR_CNT2: rd_next = cnt_reg[1];
      ADR_GRA2: rd_next = gr_w[2];
      ADR_GRB2: rd_next = gr_w[3];
      default: rd_next = RD_IDLE;
    endcase
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= RD_IDLE;
    end else if (rd_i) begin
      rd_data_o <= rd_next;
    end else begin
      rd_data_o <= RD_IDLE;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence flag_clear_s;
    wr_i && addr_i == ADR_STATUS && wr_data_i[0] && !event_w[0];
  endsequence

  ioctl_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == ADR_IOCTL2) |=> ioctl_reg[1] == $past(wr_data_i[IOCTL_W-1:0]))
    else $error("control register write lost");

  flag_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    event_w[0] |=> flag_reg[0])
    else $error("event did not set its flag");

  flag_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    flag_clear_s |=> !flag_reg[0])
    else $error("write one did not clear flag");

  irq_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    irq_o == |(flag_reg & mask_reg))
    else $error("interrupt does not follow masked flags");

  b_undriven_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !ch2_pin_b_o.enable && !ch1_pin_b_o.enable)
    else $error("b pin driven");

  a_enable_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ioctl_reg[0][FLD_A_LSB +: FIELD_W] == 4'h1) [*2] |-> ch1_pin_a_o.enable)
    else $error("compare output not enabled");

  a_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ($past(ioctl_reg[1][FLD_A_LSB +: FIELD_W]) == 4'h4) |-> !ch2_pin_a_o.enable)
    else $error("disabled output still driven");

  high_match_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (run_reg[0] && ioctl_reg[0][FLD_A_LSB +: FIELD_W] == 4'h2 && cnt_reg[0] == gr_w[0])
    |=> ch1_pin_a_o.drive)
    else $error("match did not drive high");

  low_match_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (run_reg[1] && ioctl_reg[1][FLD_A_LSB +: FIELD_W] == 4'h5 && cnt_reg[1] == gr_w[2])
    |=> !ch2_pin_a_o.drive)
    else $error("match did not drive low");

  init_high_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!run_reg[0] && ioctl_reg[0][FLD_A_LSB +: FIELD_W] == 4'h6) |=> ch1_pin_a_o.drive)
    else $error("initial level one not applied");

  cnt_step_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (run_reg[0] && !(wr_i && addr_i == ADR_CNT1)) |=> cnt_reg[0] == $past(cnt_reg[0]) + CNT_ONE)
    else $error("running counter did not step");

  read_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !rd_i |=> rd_data_o == RD_IDLE)
    else $error("read data outside read cycle");

  read_flags_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == ADR_STATUS) |=> rd_data_o[NUM_UNIT-1:0] == $past(flag_reg))
    else $error("status read mismatch");

  both_edges_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ioctl_reg[0][FLD_A_LSB +: FIELD_W] == 4'hA && g_unit[0].u_gr.fall)
    |-> event_w[0])
    else $error("falling edge missed in both-edge mode");

  // capture edges and loads per unit, and an event beating a same-cycle clear
  fall_capture_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ioctl_reg[0][FLD_A_LSB +: FIELD_W] == 4'h9 && g_unit[0].u_gr.fall) |-> event_w[0])
    else $error("falling edge missed");

  rise_ch2a_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ioctl_reg[1][FLD_A_LSB +: FIELD_W] == 4'hC && g_unit[2].u_gr.rise) |-> event_w[2])
    else $error("channel 2 a edge missed");

  b_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    g_unit[3].u_gr.cap_hit |=> gr_w[3] == $past(cnt_reg[1]))
    else $error("b capture did not load counter");

  b_fall_only_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ioctl_reg[1][FLD_B_LSB +: FIELD_W] == 4'hD && g_unit[3].u_gr.rise) |-> !event_w[3])
    else $error("rising edge captured in falling mode");

  set_wins_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (event_w[0] && wr_i && addr_i == ADR_STATUS) |=> flag_reg[0])
    else $error("clear beat a same-cycle event");

  // compare output of channel 1 register a
  toggle_match_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (run_reg[0] && ioctl_reg[0][FLD_A_LSB +: FIELD_W] == 4'h3 && cnt_reg[0] == gr_w[0])
    |=> ch1_pin_a_o.drive != $past(ch1_pin_a_o.drive))
    else $error("match did not toggle");

  init_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!run_reg[0] && ioctl_reg[0][FLD_A_LSB +: FIELD_W] == 4'h1) |=> !ch1_pin_a_o.drive)
    else $error("initial level zero not applied");

  a_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (run_reg[0] && cnt_reg[0] != gr_w[0]) |=> $stable(ch1_pin_a_o.drive))
    else $error("pin level moved without match");

  a_enable_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ioctl_reg[0][FLD_A_LSB +: FIELD_W] == 4'h0) [*2] |-> !ch1_pin_a_o.enable)
    else $error("output not disabled");

  capture_no_drive_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ioctl_reg[0][FLD_A_LSB +: FIELD_W] == 4'h8) [*2] |-> !ch1_pin_a_o.enable)
    else $error("capture pin still driven");

  // register writes and reads
  gr_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (gr_we[1] && !g_unit[1].u_gr.cap_hit) |=> gr_w[1] == $past(wr_data_i))
    else $error("general register write lost");

  mask_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == ADR_MASK) |=> mask_reg == $past(wr_data_i[NUM_UNIT-1:0]))
    else $error("mask write lost");

  run_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == ADR_RUN) |=> run_reg == $past(wr_data_i[NUM_CH-1:0]))
    else $error("run bits write lost");

  read_ioctl_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == ADR_IOCTL1) |=> rd_data_o == widen($past(ioctl_reg[0])))
    else $error("control register read mismatch");

endmodule
